// >>> shared/indicator_defs.vh
`ifndef INDICATOR_DEFS_VH
`define INDICATOR_DEFS_VH
// Register byte addresses on the AXI4-Lite slave
`define ADDR_INDICATOR_CONFIG 4'h0
`define ADDR_INDICATOR_STATUS 4'h4
// Field positions inside indicator_config
`define SEL0_LSB 0
`define SEL1_LSB 4
`define SEL2_LSB 8
`define RATE_LSB 12
// Reset value: rate 10, sel2 0110, sel1 0001, sel0 0000
`define CONFIG_RESET 16'h2610
// Source selector codes
`define SRC_LINK 4'h0
`define SRC_LINK_TXRX 4'h1
`define SRC_LINK_TX 4'h2
`define SRC_LINK_RX 4'h3
`define SRC_LINK_MASTER 4'h4
`define SRC_LINK_SLAVE 4'h5
`define SRC_ACTIVITY 4'h6
`define SRC_LINK_LOST 4'h9
`define SRC_PATTERN_ERR 4'hA
// Blink half-periods in ms and clock rate in kHz
`define CLK_KHZ 20000
`define BLINK_MS_00 50
`define BLINK_MS_01 100
`define BLINK_MS_10 200
`define BLINK_MS_11 500
`define BLINK_CYC_00 (`BLINK_MS_00 * `CLK_KHZ)
`define BLINK_CYC_01 (`BLINK_MS_01 * `CLK_KHZ)
`define BLINK_CYC_10 (`BLINK_MS_10 * `CLK_KHZ)
`define BLINK_CYC_11 (`BLINK_MS_11 * `CLK_KHZ)
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10
`endif

// >>> logic/indicator_control.v
// Behaviour
// - Blink rate field 13:12, reset 10
// - Selector 3:0 drives output zero, reset 0000
// - Selector 7:4 drives output one, reset 0001
// - Selector 11:8 drives output two, reset 0110
// - Code 1001: link lost, held until status read
// - Code 1010: pattern error, held until counter cleared
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "indicator_defs.vh"
module indicator_control
#(
  parameter BLINK_CYC_00 = `BLINK_CYC_00,
  parameter BLINK_CYC_01 = `BLINK_CYC_01,
  parameter BLINK_CYC_10 = `BLINK_CYC_10,
  parameter BLINK_CYC_11 = `BLINK_CYC_11
)
(
  input wire CLK,
  input wire RST,
  input wire LINK_UP,
  input wire LINK_MASTER,
  input wire TX_ACTIVITY,
  input wire RX_ACTIVITY,
  input wire BASIC_STATUS_READ,
  input wire PATTERN_ERROR,
  input wire PATTERN_COUNT_CLEAR,
  input wire [3:0] AWADDR,
  input wire AWVALID,
  output reg AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output reg WREADY,
  output reg [1:0] BRESP,
  output reg BVALID,
  input wire BREADY,
  input wire [3:0] ARADDR,
  input wire ARVALID,
  output reg ARREADY,
  output reg [31:0] RDATA,
  output reg [1:0] RRESP,
  output reg RVALID,
  input wire RREADY,
  output reg INDICATOR_OUT_ZERO,
  output reg INDICATOR_OUT_ONE,
  output reg INDICATOR_OUT_TWO
);

////////////////////////////////////////////////////////////////////////////
// Register file and bus slave

reg [15:0] config_ff;
reg [3:0] awaddr_ff;
reg aw_held_ff;
reg [31:0] wdata_ff;
reg [3:0] wstrb_ff;
reg w_held_ff;
reg link_lost_ff;
reg pattern_err_ff;
reg blink_phase_ff;
reg [23:0] blink_cnt_ff;
reg link_prev_ff;

wire do_write = aw_held_ff && w_held_ff && !BVALID;

// Status word: bit0 link lost, bit1 pattern error, bit2 blink phase
wire [31:0] status_word = {29'h0, blink_phase_ff, pattern_err_ff,
  link_lost_ff};

// Address decode shared by the write and read paths
function is_config_addr;
  input [3:0] addr;
  begin
    is_config_addr = (addr == `ADDR_INDICATOR_CONFIG);
  end
endfunction

function is_status_addr;
  input [3:0] addr;
  begin
    is_status_addr = (addr == `ADDR_INDICATOR_STATUS);
  end
endfunction

// Each ready pulses for one cycle, so a valid held by the master is taken
// once; the response waits until both halves of the write are in
always @(posedge CLK)
begin
  if (RST)
  begin
    AWREADY <= 1'b0;
    aw_held_ff <= 1'b0;
    awaddr_ff <= 4'h0;
  end
  else
  begin
    AWREADY <= !aw_held_ff && !AWREADY && AWVALID;
    if (AWVALID && AWREADY)
    begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= AWADDR;
    end
    else if (do_write)
      aw_held_ff <= 1'b0;
  end
end

always @(posedge CLK)
begin
  if (RST)
  begin
    WREADY <= 1'b0;
    w_held_ff <= 1'b0;
    wdata_ff <= 32'h0;
    wstrb_ff <= 4'h0;
  end
  else
  begin
    WREADY <= !w_held_ff && !WREADY && WVALID;
    if (WVALID && WREADY)
    begin
      w_held_ff <= 1'b1;
      wdata_ff <= WDATA;
      wstrb_ff <= WSTRB;
    end
    else if (do_write)
      w_held_ff <= 1'b0;
  end
end

// Writes to the status word are accepted and dropped; it is read-only
always @(posedge CLK)
begin
  if (RST)
  begin
    BVALID <= 1'b0;
    BRESP <= `AXI_OKAY;
  end
  else if (do_write)
  begin
    BVALID <= 1'b1;
    if (is_config_addr(awaddr_ff) || is_status_addr(awaddr_ff))
      BRESP <= `AXI_OKAY;
    else
      BRESP <= `AXI_SLVERR;
  end
  else if (BVALID && BREADY)
    BVALID <= 1'b0;
end

// Lanes 2 and 3 have no bits behind them and are dropped
always @(posedge CLK)
begin
  if (RST)
    config_ff <= `CONFIG_RESET;
  else if (do_write && is_config_addr(awaddr_ff))
  begin
    if (wstrb_ff[0])
      config_ff[7:0] <= wdata_ff[7:0];
    if (wstrb_ff[1])
      config_ff[15:8] <= wdata_ff[15:8];
  end
end

// One read at a time: the address is taken only while no data is pending

always @(posedge CLK)
begin
  if (RST)
  begin
    ARREADY <= 1'b0;
    RVALID <= 1'b0;
    RDATA <= 32'h0;
    RRESP <= `AXI_OKAY;
  end
  else
  begin
    ARREADY <= !ARREADY && !RVALID && ARVALID;
    if (ARVALID && ARREADY)
    begin
      RVALID <= 1'b1;
      RRESP <= `AXI_OKAY;
      if (is_config_addr(ARADDR))
        RDATA <= {16'h0, config_ff};
      else if (is_status_addr(ARADDR))
        RDATA <= status_word;
      else
      begin
        RDATA <= 32'h0;
        RRESP <= `AXI_SLVERR;
      end
    end
    else if (RVALID && RREADY)
      RVALID <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////
// Blink timebase shared by all outputs

// One shared phase keeps all lamps blinking in step; a new rate takes
// effect at once since the compare below also catches an overshoot
reg [23:0] blink_limit;

always @*
begin
  case (config_ff[`RATE_LSB+1:`RATE_LSB])
    2'b00: blink_limit = BLINK_CYC_00[23:0];
    2'b01: blink_limit = BLINK_CYC_01[23:0];
    2'b10: blink_limit = BLINK_CYC_10[23:0];
    default: blink_limit = BLINK_CYC_11[23:0];
  endcase
end

always @(posedge CLK)
begin
  if (RST)
  begin
    blink_cnt_ff <= 24'h0;
    blink_phase_ff <= 1'b0;
  end
  else if (blink_cnt_ff >= blink_limit - 24'h1)
  begin
    blink_cnt_ff <= 24'h0;
    blink_phase_ff <= !blink_phase_ff;
  end
  else
    blink_cnt_ff <= blink_cnt_ff + 24'h1;
end

////////////////////////////////////////////////////////////////////////////
// Sticky indications; a new event wins over a clear in the same cycle

// The previous level resets low, matching a link that is down at reset,
// so leaving reset never looks like a loss
always @(posedge CLK)
begin
  if (RST)
  begin
    link_prev_ff <= 1'b0;
    link_lost_ff <= 1'b0;
  end
  else
  begin
    link_prev_ff <= LINK_UP;
    if (link_prev_ff && !LINK_UP)
      link_lost_ff <= 1'b1;
    else if (BASIC_STATUS_READ)
      link_lost_ff <= 1'b0;
  end
end

// An error in the cycle of a counter clear keeps the lamp lit, so no
// error goes unseen
always @(posedge CLK)
begin
  if (RST)
    pattern_err_ff <= 1'b0;
  else if (PATTERN_ERROR)
    pattern_err_ff <= 1'b1;
  else if (PATTERN_COUNT_CLEAR)
    pattern_err_ff <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////
// Source selection, one decoder shared by the three outputs

// Reserved codes give a dark output rather than anything misleading
function source_level;
  input [3:0] sel;
  reg act;
  begin
    act = 1'b0;
    source_level = 1'b0;
    case (sel)
      `SRC_LINK: source_level = LINK_UP;
      `SRC_LINK_TXRX: act = TX_ACTIVITY || RX_ACTIVITY;
      `SRC_LINK_TX: act = TX_ACTIVITY;
      `SRC_LINK_RX: act = RX_ACTIVITY;
      `SRC_LINK_MASTER: source_level = LINK_UP && LINK_MASTER;
      `SRC_LINK_SLAVE: source_level = LINK_UP && !LINK_MASTER;
      `SRC_ACTIVITY:
        source_level = (TX_ACTIVITY || RX_ACTIVITY) && blink_phase_ff;
      `SRC_LINK_LOST: source_level = link_lost_ff;
      `SRC_PATTERN_ERR: source_level = pattern_err_ff;
      default: source_level = 1'b0;
    endcase
    if (sel == `SRC_LINK_TXRX || sel == `SRC_LINK_TX ||
        sel == `SRC_LINK_RX)
      source_level = LINK_UP && (!act || blink_phase_ff);
  end
endfunction

// Registered drives keep the lamps glitch-free while the config changes
always @(posedge CLK)
begin
  if (RST)
  begin
    INDICATOR_OUT_ZERO <= 1'b0;
    INDICATOR_OUT_ONE <= 1'b0;
    INDICATOR_OUT_TWO <= 1'b0;
  end
  else
  begin
    INDICATOR_OUT_ZERO <= source_level(config_ff[3:0]);
    INDICATOR_OUT_ONE <= source_level(config_ff[7:4]);
    INDICATOR_OUT_TWO <= source_level(config_ff[11:8]);
  end
end

endmodule

// >>> tb/indicator_checker.sv
`timescale 1ns/100ps
module indicator_checker
(
  input wire CLK,
  input wire RST,
  input wire LINK_UP,
  input wire LINK_MASTER,
  input wire TX_ACTIVITY,
  input wire RX_ACTIVITY,
  input wire BASIC_STATUS_READ,
  input wire PATTERN_ERROR,
  input wire PATTERN_COUNT_CLEAR,
  input wire [3:0] AWADDR,
  input wire [31:0] WDATA,
  input wire WVALID,
  input wire WREADY,
  input wire BVALID,
  input wire BREADY,
  input wire INDICATOR_OUT_ZERO,
  input wire INDICATOR_OUT_ONE,
  input wire INDICATOR_OUT_TWO
);
  reg [15:0] cfg_ff;
  reg wr_ff;
  reg wr2_ff;
  wire [3:0] s0 = cfg_ff[3:0];
  wire z = INDICATOR_OUT_ZERO;
  wire idle = !TX_ACTIVITY && !RX_ACTIVITY;
  // Checks rest while a write is in flight and one cycle beyond, since
  // the lamps follow a new config a cycle after it lands
  always @(posedge CLK)
  begin
    wr2_ff <= !RST && wr_ff;
    if (RST || BVALID && BREADY)
      wr_ff <= 1'h0;
    else if (WVALID && WREADY)
      wr_ff <= 1'h1;
    if (RST)
      cfg_ff <= 16'h2610;
    else if (WVALID && WREADY && AWADDR == 4'h0)
      cfg_ff <= WDATA[15:0];
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST || wr_ff || wr2_ff);
  sequence s_lost; s0 == 4'h9 && $fell(LINK_UP); endsequence
  sequence s_bad; s0 == 4'hA && PATTERN_ERROR; endsequence
  sequence s_held; !BASIC_STATUS_READ ##1 s0 == 4'h9 && z; endsequence
  property p_link; s0 == 4'h0 |=> z == $past(LINK_UP); endproperty
  a_link: assert property (p_link) else $error("zero");
  property p_mst;
    cfg_ff[7:4] == 4'h4 |=>
      INDICATOR_OUT_ONE == $past(LINK_MASTER && LINK_UP);
  endproperty
  a_mst: assert property (p_mst) else $error("one");
  property p_slv;
    cfg_ff[11:8] == 4'h5 |=>
      INDICATOR_OUT_TWO == $past(LINK_UP && !LINK_MASTER);
  endproperty
  a_slv: assert property (p_slv) else $error("two");
  property p_on; s0 == 4'h1 && LINK_UP && idle |=> z; endproperty
  a_on: assert property (p_on) else $error("steady");
  property p_idle;
    cfg_ff[11:8] == 4'h6 && idle |=> !INDICATOR_OUT_TWO;
  endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_lost; s_lost |-> ##[1:2] z; endproperty
  a_lost: assert property (p_lost) else $error("lost");
  property p_keep; s_held ##0 !BASIC_STATUS_READ |=> z; endproperty
  a_keep: assert property (p_keep) else $error("keep");
  property p_err; s_bad |-> ##[1:2] z; endproperty
  a_err: assert property (p_err) else $error("error");
endmodule

// >>> tb/lamp_model.sv
`timescale 1ns/100ps
module lamp_model
(
  input wire [2:0] drive,
  output wire [2:0] glow
);
  // Lamps hold no memory, so any stuck blink shows at once
  assign glow = drive;
endmodule

// >>> tb/status_led_source_control_tb.sv
`timescale 1ns/100ps
`define CHK(a,b) n_checks++; if ((a) !== (b)) begin err_total++; \
$display("[FAIL] %0t %h not %h", $time, a, b); end
`define P(s) s <= 1'h1; tk(1); s <= 1'h0;
module status_led_source_control_tb;
  reg CLK, RST, LINK_UP, LINK_MASTER, TX_ACTIVITY, RX_ACTIVITY;
  reg BASIC_STATUS_READ, PATTERN_ERROR, PATTERN_COUNT_CLEAR;
  reg AWVALID, WVALID, BREADY, ARVALID, RREADY;
  reg [3:0] AWADDR, ARADDR, WSTRB;
  reg [31:0] WDATA, d;
  reg [1:0] r;
  wire AWREADY, WREADY, BVALID, ARREADY, RVALID;
  wire [1:0] BRESP, RRESP;
  wire [31:0] RDATA;
  wire INDICATOR_OUT_ZERO, INDICATOR_OUT_ONE, INDICATOR_OUT_TWO;
  wire [2:0] glow;
  int err_total, n_checks, i, n;
  indicator_control #(4, 6, 8, 10) indicator_control_i (.*);
  lamp_model lamp_model_i (.drive({INDICATOR_OUT_TWO, INDICATOR_OUT_ONE,
    INDICATOR_OUT_ZERO}), .glow(glow));
  task print_verdict;
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task tk(input int c);
    repeat (c) @(posedge CLK);
  endtask
  task lim;
    if (i > 98)
    begin
      err_total++;
      print_verdict;
    end
  endtask
  // Leading edge keeps a strobe from being set twice in one step
  task wr(input [15:0] v);
    tk(1);
    WDATA <= {16'h0, v};
    AWVALID <= 1'h1;
    WVALID <= 1'h1;
    BREADY <= 1'h1;
    i = 0;
    do
    begin
      tk(1);
      if (AWREADY)
        AWVALID <= 1'h0;
      if (WREADY)
        WVALID <= 1'h0;
      i++;
    end while (i < 99 && !BVALID);
    r = BRESP;
    BREADY <= 1'h0;
    lim;
  endtask
  task rd(input [3:0] a);
    tk(1);
    ARADDR <= a;
    ARVALID <= 1'h1;
    RREADY <= 1'h1;
    i = 0;
    do
    begin
      tk(1);
      if (ARREADY)
        ARVALID <= 1'h0;
      i++;
    end while (i < 99 && !RVALID);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'h0;
    lim;
  endtask
  task chg;
    n = 0;
    d[0] = glow[2];
    do
    begin
      tk(1);
      n++;
    end while (glow[2] === d[0] && n < 99);
    if (n >= 99)
    begin
      err_total++;
      print_verdict;
    end
  endtask
  task t_regs;
    LINK_UP <= 1'h1;
    tk(3);
    `CHK(glow[0], 1'h1)
    rd(4'h0);
    `CHK(d, 32'h2610)
    wr(16'h0541);
    `CHK(r, 2'h0)
    rd(4'h0);
    `CHK(d, 32'h0541)
    rd(4'h8);
    `CHK({d, r}, 34'h2)
  endtask
  task t_map;
    for (n = 0; n < 4; n++)
    begin
      LINK_UP <= n[1];
      LINK_MASTER <= n[0];
      tk(3);
      `CHK(glow, {n[1] & !n[0], n[1] & n[0], n[1]})
    end
  endtask
  task t_blink;
    for (int k = 0; k < 4; k++)
    begin
      wr({2'h0, k[1:0], 12'h641});
      TX_ACTIVITY <= !k[0];
      RX_ACTIVITY <= k[0];
      chg;
      chg;
      `CHK(n, 4 + 2 * k)
    end
    TX_ACTIVITY <= 1'h0;
    RX_ACTIVITY <= 1'h0;
  endtask
  task t_lost;
    wr(16'h2649);
    `P(BASIC_STATUS_READ)
    tk(3);
    `CHK(glow[0], 1'h0)
    LINK_UP <= 1'h0;
    tk(2);
    LINK_UP <= 1'h1;
    tk(20);
    `CHK(glow[0], 1'h1)
    rd(4'h4);
    `CHK(d[1:0], 2'h1)
    `P(BASIC_STATUS_READ)
    tk(3);
    `CHK(glow[0], 1'h0)
  endtask
  task t_prbs;
    wr(16'h264A);
    tk(2);
    `CHK(glow[0], 1'h0)
    `P(PATTERN_ERROR)
    tk(20);
    `CHK(glow[0], 1'h1)
    `P(PATTERN_COUNT_CLEAR)
    tk(3);
    `CHK(glow[0], 1'h0)
  endtask
  initial
  begin
    CLK = 1'h0;
    forever #25 CLK = ~CLK;
  end
  initial
  begin
    {RST, LINK_UP, LINK_MASTER, TX_ACTIVITY, RX_ACTIVITY} = 5'h10;
    {BASIC_STATUS_READ, PATTERN_ERROR, PATTERN_COUNT_CLEAR} = 3'h0;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h0;
    {AWADDR, ARADDR, WSTRB, WDATA} = 44'h00F00000000;
    err_total = 0;
    n_checks = 0;
    tk(20);
    RST <= 1'h0;
    t_regs;
    t_map;
    t_blink;
    t_lost;
    t_prbs;
    print_verdict;
  end
endmodule
bind indicator_control indicator_checker indicator_checker_i (.*);
